// [core/bsd_pkg.sv]
/*
 Package for the boot strap option decoder: mode codes, baud rate values,
 switch field positions and the decoded settings carrier.
 Assumes nothing beyond a SystemVerilog elaborator.
*/
package bsd_pkg;

   // Start-up modes chosen by the mode strap.
   typedef enum logic [1:0] {
      BSD_MODE_NONE    = 2'b00,
      BSD_MODE_MONITOR = 2'b01,
      BSD_MODE_AUTOBOOT = 2'b10,
      BSD_MODE_CONFLICT = 2'b11
   } bsd_mode_type;

   // Sampler states.
   typedef enum logic [1:0] {
      BSD_ST_RESET  = 2'b00,
      BSD_ST_SETTLE = 2'b01,
      BSD_ST_HOLD   = 2'b10
   } bsd_state_type;

   // Switch field positions, switch one is bit 0.
   localparam int BSD_CON_LSB  = 0;
   localparam int BSD_PRN_LSB  = 3;
   localparam int BSD_SPARE_A  = 5;
   localparam int BSD_SPARE_B  = 6;
   localparam int BSD_MAINT    = 7;

   // Settle count: three-stage synchroniser plus one agreement cycle.
   localparam logic [2:0] BSD_SETTLE_CYCLES = 3'h4;

   // Baud rate values.
   localparam logic [15:0] BSD_BAUD_110   = 16'h006E;
   localparam logic [15:0] BSD_BAUD_300   = 16'h012C;
   localparam logic [15:0] BSD_BAUD_600   = 16'h0258;
   localparam logic [15:0] BSD_BAUD_1200  = 16'h04B0;
   localparam logic [15:0] BSD_BAUD_2400  = 16'h0960;
   localparam logic [15:0] BSD_BAUD_4800  = 16'h12C0;
   localparam logic [15:0] BSD_BAUD_9600  = 16'h2580;
   localparam logic [15:0] BSD_BAUD_19200 = 16'h4B00;

   // Reset values of the decoded settings.
   localparam logic [2:0]  BSD_CON_CODE_RESET = 3'h6;
   localparam logic [1:0]  BSD_PRN_CODE_RESET = 2'h0;

   // Decoded settings that travel together.
   typedef struct packed {
      bsd_mode_type mode;
      logic [2:0]   con_code;
      logic [15:0]  con_baud;
      logic [1:0]   prn_code;
      logic [15:0]  prn_baud;
      logic         maint_closed;
   } bsd_settings_type;

endpackage

// [core/bsd_decoder.sv]
/*
 Boot strap option decoder. Samples the mode strap pins and the eight
 system environment switches once after reset and holds the decoded
 start-up mode and baud rates until the next reset; also reports the
 fixed grant priority position of a slot.
 The block has no clock enable and no bus: every setting is a plain port,
 and every output leaves from a flip-flop.
 Assumes switch and strap pins are asynchronous levels, high when open,
 that they are set before reset is released and left alone afterwards,
 and that the grant daisy chain itself, with its filled slots, lives on
 the backplane outside this block.
*/
`timescale 1ns/1ps

module bsd_decoder (
   // Clock and reset.
   input  wire logic                    core_clk,
   input  wire logic                    rst_b,
   // Strap pins, high when not joined to the common pin.
   input  wire logic                    debugger_option_pin,
   input  wire logic                    autoboot_option_pin,
   // Environment switches, bit 0 is switch one, high when open.
   input  wire logic [7:0]              env_switch,
   // Slot position query: 0 board, 1..6 primary A-F, 7..14 secondary H-P.
   input  wire logic [3:0]              slot_pos,
   // Decoded settings.
   output bsd_pkg::bsd_settings_type    settings,
   output logic                         settings_valid,
   output logic                         hex_debug_monitor_state,
   output logic                         autoboot_start,
   output logic [3:0]                   slot_rank
);

   // Synchroniser stages, sampler state and the captured codes.
   logic [9:0]                  sync1;
   logic [9:0]                  sync2;
   logic [9:0]                  sync3;
   logic [2:0]                  settle_cnt;
   bsd_pkg::bsd_state_type      state;
   logic [2:0]                  con_code;
   logic [1:0]                  prn_code;
   bsd_pkg::bsd_mode_type       mode;
   logic                        maint_held;
   logic                        capture_now;
   logic                        in_hold;

   // Console rate lookup.
   function automatic logic [15:0] con_rate(input logic [2:0] code);
      case (code)
         3'h0: con_rate = bsd_pkg::BSD_BAUD_110;
         3'h1: con_rate = bsd_pkg::BSD_BAUD_300;
         3'h2: con_rate = bsd_pkg::BSD_BAUD_600;
         3'h3: con_rate = bsd_pkg::BSD_BAUD_1200;
         3'h4: con_rate = bsd_pkg::BSD_BAUD_2400;
         3'h5: con_rate = bsd_pkg::BSD_BAUD_4800;
         3'h6: con_rate = bsd_pkg::BSD_BAUD_9600;
         default: con_rate = bsd_pkg::BSD_BAUD_19200;
      endcase
   endfunction

   // Printer rate lookup; code bit 0 is switch four closed.
   function automatic logic [15:0] prn_rate(input logic [1:0] code);
      case (code)
         2'h0: prn_rate = bsd_pkg::BSD_BAUD_9600;
         2'h1: prn_rate = bsd_pkg::BSD_BAUD_1200;
         2'h2: prn_rate = bsd_pkg::BSD_BAUD_300;
         default: prn_rate = bsd_pkg::BSD_BAUD_110;
      endcase
   endfunction

   // Capture is due once the settle count has run out and stages two and
   // three agree; the count keeps the reset pattern out of the sample.
   function automatic logic capture_due(input bsd_pkg::bsd_state_type st,
                                        input logic [2:0]             cnt,
                                        input logic [9:0]             stage2,
                                        input logic [9:0]             stage3);
      capture_due = (st == bsd_pkg::BSD_ST_SETTLE) &&
                    (cnt >= bsd_pkg::BSD_SETTLE_CYCLES) && (stage2 == stage3);
   endfunction

   // Strap decode: a low pin is joined to the common pin and reads as set.
   // Bit 1 is the autoboot strap and bit 0 the debugger strap.
   function automatic bsd_pkg::bsd_mode_type strap_mode(input logic [1:0] pins);
      strap_mode = bsd_pkg::bsd_mode_type'(~pins);
   endfunction

   // Grant rank of a slot position; a lower rank is served first.
   // Positions past the last secondary slot report rank 15, the last served.
   function automatic logic [3:0] grant_rank(input logic [3:0] pos);
      grant_rank = (pos > 4'hE) ? 4'hF : pos;
   endfunction

   // One capture decision shared by the sampler and the capture registers.
   assign capture_now = capture_due(state, settle_cnt, sync2, sync3);

   // Three-stage synchroniser; only stages two and three are compared.
   // Stage one may settle late after a switch bounce, so nothing else reads it.
   // Reset loads all-ones, the level of every open switch and unjoined strap.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         sync1 <= 10'h3FF;
         sync2 <= 10'h3FF;
         sync3 <= 10'h3FF;
      end else begin
         sync1 <= {autoboot_option_pin, debugger_option_pin, env_switch};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Settle, then capture once when stages agree, then hold until reset.
   // The count lets the all-ones reset pattern leave the synchroniser first,
   // so a strap that is joined cannot be missed on the first sample.
   // Pins that never agree keep the sampler waiting with valid low.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state      <= bsd_pkg::BSD_ST_RESET;
         settle_cnt <= 3'h0;
      end else begin
         case (state)
            bsd_pkg::BSD_ST_RESET: begin
               state      <= bsd_pkg::BSD_ST_SETTLE;
               settle_cnt <= 3'h0;
            end
            bsd_pkg::BSD_ST_SETTLE: begin
               if (settle_cnt < bsd_pkg::BSD_SETTLE_CYCLES) begin
                  settle_cnt <= settle_cnt + 3'h1;
               end else if (capture_now) begin
                  state <= bsd_pkg::BSD_ST_HOLD;
               end
            end
            bsd_pkg::BSD_ST_HOLD: state <= bsd_pkg::BSD_ST_HOLD;
            default: state <= bsd_pkg::BSD_ST_RESET;
         endcase
      end
   end

   // Capture codes; closed (low) counts as 1, so the code is the inverse.
   // This is the only place the pins reach the settings, so a later change
   // of a switch or strap has no effect until the next reset.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         con_code   <= bsd_pkg::BSD_CON_CODE_RESET;
         prn_code   <= bsd_pkg::BSD_PRN_CODE_RESET;
         mode       <= bsd_pkg::BSD_MODE_MONITOR;
         maint_held <= 1'b0;
      end else if (capture_now) begin
         con_code   <= ~sync3[bsd_pkg::BSD_CON_LSB +: 3];
         prn_code   <= ~sync3[bsd_pkg::BSD_PRN_LSB +: 2];
         // A low strap pin means it is joined to the common pin.
         mode       <= strap_mode(sync3[9:8]);
         // Held like the rest, so the reported switch cannot move after capture.
         maint_held <= ~sync3[bsd_pkg::BSD_MAINT];
      end
   end

   // Settings fields follow the captured codes through the rate lookup.
   // Code and rate both come from the capture registers, so they change
   // on the same edge and never disagree on the port.
   // Switches six and seven pass through the synchroniser but reach no capture register or settings field.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         settings <= '{bsd_pkg::BSD_MODE_MONITOR,
                       bsd_pkg::BSD_CON_CODE_RESET, bsd_pkg::BSD_BAUD_9600,
                       bsd_pkg::BSD_PRN_CODE_RESET, bsd_pkg::BSD_BAUD_9600,
                       1'b0};
      end else begin
         settings.mode         <= mode;
         settings.con_code     <= con_code;
         settings.con_baud     <= con_rate(con_code);
         settings.prn_code     <= prn_code;
         settings.prn_baud     <= prn_rate(prn_code);
         // Status only: a closed maintenance switch is reported, not acted on.
         settings.maint_closed <= maint_held;
      end
   end

   // Sampler state as a plain level, shared by valid and the start flags.
   assign in_hold = (state == bsd_pkg::BSD_ST_HOLD);

   // Settings valid from the cycle after the first held cycle until the next reset.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         settings_valid <= 1'b0;
      end else begin
         settings_valid <= in_hold;
      end
   end

   // Start-up flags, raised together with valid and never before it.
   // Debugger wins if both straps are joined, the safer start.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         hex_debug_monitor_state <= 1'b0;
         autoboot_start          <= 1'b0;
      end else begin
         hex_debug_monitor_state <= in_hold && mode[0];
         autoboot_start          <= in_hold && (mode == bsd_pkg::BSD_MODE_AUTOBOOT);
      end
   end

   // Fixed grant rank: lower is served first; the chain itself is outside.
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         slot_rank <= 4'h0;
      end else begin
         slot_rank <= grant_rank(slot_pos);
      end
   end

endmodule

// [dv/bsd_decoder_properties.sv]
/* Checker for the boot strap option decoder.
   Bound to bsd_decoder at the foot of this file; sees only its ports. */
`timescale 1ns/1ps
module bsd_decoder_checker (
   // Clock, reset and query.
   input wire logic                      core_clk,
   input wire logic                      rst_b,
   input wire logic [3:0]                slot_pos,
   // Decoded outputs.
   input wire bsd_pkg::bsd_settings_type settings,
   input wire logic                      settings_valid,
   input wire logic                      hex_debug_monitor_state,
   input wire logic                      autoboot_start,
   input wire logic [3:0]                slot_rank
);
   // Expected rates, indexed by the decoded codes.
   localparam logic [15:0] CON [0:7] = '{bsd_pkg::BSD_BAUD_110, bsd_pkg::BSD_BAUD_300,
      bsd_pkg::BSD_BAUD_600, bsd_pkg::BSD_BAUD_1200, bsd_pkg::BSD_BAUD_2400,
      bsd_pkg::BSD_BAUD_4800, bsd_pkg::BSD_BAUD_9600, bsd_pkg::BSD_BAUD_19200};
   localparam logic [15:0] PRN [0:3] = '{bsd_pkg::BSD_BAUD_9600, bsd_pkg::BSD_BAUD_1200,
      bsd_pkg::BSD_BAUD_300, bsd_pkg::BSD_BAUD_110};
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Fields are final on the same edge that valid rises; the checks built on s_held still require two valid samples.
   sequence s_held;
      settings_valid ##1 settings_valid;
   endsequence
   sequence s_capture;
      !settings_valid [*3] ##[1:12] settings_valid;
   endsequence
   chk_capture_time: assert property ($rose(rst_b) |-> s_capture)
      else $error("settings never captured");
   chk_valid_hold: assert property (settings_valid |=> settings_valid)
      else $error("valid dropped");
   chk_fields_held: assert property (s_held |=> $stable({settings.mode,
      settings.con_code, settings.con_baud, settings.prn_code, settings.prn_baud,
      settings.maint_closed})) else $error("settings moved");
   chk_con_baud: assert property (s_held |-> settings.con_baud == CON[settings.con_code])
      else $error("console rate wrong");
   chk_prn_baud: assert property (s_held |-> settings.prn_baud == PRN[settings.prn_code])
      else $error("printer rate wrong");
   chk_mode_flags: assert property (s_held |-> hex_debug_monitor_state ==
      settings.mode[0] && autoboot_start == (settings.mode == bsd_pkg::BSD_MODE_AUTOBOOT))
      else $error("start flags wrong");
   chk_idle_quiet: assert property (!settings_valid |->
      !hex_debug_monitor_state && !autoboot_start) else $error("start before capture");
   chk_reset_default: assert property ($rose(rst_b) |-> settings.con_code == 3'h6 &&
      settings.mode == bsd_pkg::BSD_MODE_MONITOR) else $error("reset default wrong");
   chk_rank_map: assert property (rst_b |=> slot_rank ==
      (($past(slot_pos) > 4'hE) ? 4'hF : $past(slot_pos))) else $error("rank wrong");
endmodule
bind bsd_decoder bsd_decoder_checker bsd_decoder_checker_i (.core_clk, .rst_b, .slot_pos,
   .settings, .settings_valid, .hex_debug_monitor_state, .autoboot_start, .slot_rank);

// [dv/bsd_decoder_tb.sv]
/* Self-checking bench for the boot strap option decoder.
   Drives pins at the falling edge; needs bsd_pkg and the bound checker. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module bsd_decoder_tb;
   // Pins, outputs and counters.
   logic                      core_clk = 1'b0;
   logic                      rst_b = 1'b0;
   logic                      debugger_option_pin = 1'b1;
   logic                      autoboot_option_pin = 1'b1;
   logic [7:0]                env_switch = 8'hFF;
   logic [3:0]                slot_pos = 4'h0;
   bsd_pkg::bsd_settings_type settings;
   logic                      settings_valid;
   logic                      hex_debug_monitor_state;
   logic                      autoboot_start;
   logic [3:0]                slot_rank;
   logic [4:0]                i;
   int                        fails = 0;
   int                        n_checks = 0;
   // Clock at 50 MHz.
   always #10 core_clk = ~core_clk;
   bsd_decoder bsd_decoder_i (.core_clk, .rst_b, .debugger_option_pin, .autoboot_option_pin,
      .env_switch, .slot_pos, .settings, .settings_valid, .hex_debug_monitor_state,
      .autoboot_start, .slot_rank);
   // Prints the verdict and stops.
   task automatic wrap_up();
      if (fails == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Boots once with the given pins, checks, then moves the pins to prove they are ignored.
   task automatic boot_case(input logic dbg, input logic ab, input logic [7:0] sw);
      logic [2:0] cc;
      logic [1:0] pc;
      int         w;
      logic [15:0] con [0:7];
      logic [15:0] prn [0:3];
      con = '{16'h006E, 16'h012C, 16'h0258, 16'h04B0, 16'h0960, 16'h12C0, 16'h2580, 16'h4B00};
      prn = '{16'h2580, 16'h04B0, 16'h012C, 16'h006E};
      cc = ~sw[2:0];
      pc = ~sw[4:3];
      rst_b = 1'b0;
      debugger_option_pin = dbg;
      autoboot_option_pin = ab;
      env_switch = sw;
      repeat (4) @(negedge core_clk);
      rst_b = 1'b1;
      for (w = 0; w < 20 && settings_valid !== 1'b1; w++) @(negedge core_clk);
      repeat (2) @(negedge core_clk);
      `CHK("valid", 1'b1, settings_valid)
      `CHK("mode", ({~ab, ~dbg}), settings.mode)
      `CHK("monitor", ~dbg, hex_debug_monitor_state)
      `CHK("autoboot", ~ab & dbg, autoboot_start)
      `CHK("con_code", cc, settings.con_code)
      `CHK("con_baud", con[cc], settings.con_baud)
      `CHK("prn_baud", prn[pc], settings.prn_baud)
      `CHK("maint", ~sw[7], settings.maint_closed)
      debugger_option_pin = ~dbg;
      autoboot_option_pin = ~ab;
      env_switch = ~sw;
      // Long enough for a moved pin to cross all three stages and reach the ports.
      repeat (8) @(negedge core_clk);
      `CHK("held_mode", ({~ab, ~dbg}), settings.mode)
      `CHK("held_codes", ({cc, pc}), ({settings.con_code, settings.prn_code}))
      `CHK("held_maint", ~sw[7], settings.maint_closed)
   endtask
   // Default setting, then every console code, printer code, strap pair and spare pattern.
   initial begin
      boot_case(1'b0, 1'b1, 8'hF9);
      for (i = 5'h00; i < 5'h08; i++) begin
         boot_case(i[0], i[1], {i[2], i[1:0], ~i[1:0], ~i[2:0]});
      end
      // Every slot position and one beyond the last.
      for (i = 5'h00; i < 5'h10; i++) begin
         slot_pos = i[3:0];
         @(negedge core_clk);
         `CHK("rank", (i > 5'h0E) ? 4'hF : i[3:0], slot_rank)
      end
      wrap_up();
   end
   // Watchdog well beyond the few hundred cycles the tests need.
   initial begin
      repeat (2000) @(posedge core_clk);
      fails++;
      wrap_up();
   end
endmodule
